//--- design/bcp_pkg.sv
/*
 * Constants, types and the parameter table of the binary command port.
 * Assumes a UART receiver and transmitter on sys_clk outside the block.
 */
package bcp_pkg;

	typedef enum logic [1:0] {ACC_RW, ACC_RO, ACC_MIXED} bcp_access_t;

	typedef struct packed {
		logic [7:0]  offset;
		logic        wide;
		bcp_access_t access;
		logic [15:0] reset_value;
	} bcp_reg_t;

	localparam bcp_reg_t REG_DEST_ADDRESS         = '{8'h00, 1'b1, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_SLEEP_SELECT         = '{8'h01, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_SLEEP_IDLE_DELAY     = '{8'h02, 1'b1, ACC_RW, 16'h0064};
	localparam bcp_reg_t REG_WAKE_INIT_DELAY      = '{8'h03, 1'b1, ACC_RW, 16'hffff};
	localparam bcp_reg_t REG_GUARD_BEFORE         = '{8'h04, 1'b1, ACC_RW, 16'h000a};
	localparam bcp_reg_t REG_GUARD_AFTER          = '{8'h05, 1'b1, ACC_RW, 16'h000a};
	localparam bcp_reg_t REG_COMMAND_IDLE_TIMEOUT = '{8'h06, 1'b1, ACC_RW, 16'h00c8};
	localparam bcp_reg_t REG_XON_XOFF_ENABLE      = '{8'h07, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_WAKE_INIT_LENGTH     = '{8'h0c, 1'b0, ACC_RW, 16'h0001};
	localparam bcp_reg_t REG_RX_BAD_PACKETS       = '{8'h0f, 1'b1, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_RX_GOOD_COUNT        = '{8'h10, 1'b1, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_HOP_CHANNEL          = '{8'h11, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_ADDRESS_MASK         = '{8'h12, 1'b1, ACC_RW, 16'hffff};
	localparam bcp_reg_t REG_ESCAPE_CHAR          = '{8'h13, 1'b0, ACC_RW, 16'h002b};
	localparam bcp_reg_t REG_FIRMWARE_VERSION     = '{8'h14, 1'b1, ACC_RO, 16'h0000};
	localparam bcp_reg_t REG_UART_BAUD_CODE       = '{8'h15, 1'b1, ACC_RW, 16'h0003};
	localparam bcp_reg_t REG_LINE2_INPUT_FUNCTION = '{8'h16, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_INIT_QUIET_DELAY     = '{8'h17, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_RETRY_LIMIT          = '{8'h18, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_SLOT_DELAY           = '{8'h19, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_STREAM_LIMIT         = '{8'h1a, 1'b1, ACC_RW, 16'hffff};
	localparam bcp_reg_t REG_TX_ERROR_COUNT       = '{8'h1b, 1'b1, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_SIGNAL_STRENGTH      = '{8'h1c, 1'b0, ACC_RO, 16'h0000};
	localparam bcp_reg_t REG_PIN_WAKE_ENABLE      = '{8'h1d, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_POWERUP_MODE         = '{8'h1e, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_OUT2_FUNCTION        = '{8'h1f, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_PACKET_THRESHOLD     = '{8'h20, 1'b1, ACC_RW, 16'h0001};
	localparam bcp_reg_t REG_PACKET_TIMEOUT       = '{8'h21, 1'b1, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_RSSI_PWM_TIME        = '{8'h22, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_PARITY_SELECT        = '{8'h23, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_FLOW_THRESHOLD       = '{8'h24, 1'b1, ACC_RW, 16'h0040};
	localparam bcp_reg_t REG_SERIAL_HIGH          = '{8'h25, 1'b1, ACC_RO, 16'h0000};
	localparam bcp_reg_t REG_SERIAL_LOW           = '{8'h26, 1'b1, ACC_RO, 16'h0000};
	localparam bcp_reg_t REG_NETWORK_TAG          = '{8'h27, 1'b1, ACC_MIXED, 16'h7fff};
	localparam bcp_reg_t REG_OUT3_FUNCTION        = '{8'h28, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_PACKET_SIZE          = '{8'h29, 1'b1, ACC_RW, 16'h0040};
	localparam bcp_reg_t REG_SOURCE_ADDRESS       = '{8'h2a, 1'b1, ACC_RW, 16'hffff};
	localparam bcp_reg_t REG_RF_MODE_SELECT       = '{8'h32, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_STOP_BITS            = '{8'h36, 1'b0, ACC_RW, 16'h0000};
	localparam bcp_reg_t REG_TX_POWER_LEVEL       = '{8'h3c, 1'b0, ACC_RW, 16'h0004};

	localparam int REG_COUNT = 40;
	localparam bcp_reg_t REG_LIST [REG_COUNT] = '{
		REG_DEST_ADDRESS, REG_SLEEP_SELECT, REG_SLEEP_IDLE_DELAY, REG_WAKE_INIT_DELAY,
		REG_GUARD_BEFORE, REG_GUARD_AFTER, REG_COMMAND_IDLE_TIMEOUT, REG_XON_XOFF_ENABLE,
		REG_WAKE_INIT_LENGTH, REG_RX_BAD_PACKETS, REG_RX_GOOD_COUNT, REG_HOP_CHANNEL,
		REG_ADDRESS_MASK, REG_ESCAPE_CHAR, REG_FIRMWARE_VERSION, REG_UART_BAUD_CODE,
		REG_LINE2_INPUT_FUNCTION, REG_INIT_QUIET_DELAY, REG_RETRY_LIMIT, REG_SLOT_DELAY,
		REG_STREAM_LIMIT, REG_TX_ERROR_COUNT, REG_SIGNAL_STRENGTH, REG_PIN_WAKE_ENABLE,
		REG_POWERUP_MODE, REG_OUT2_FUNCTION, REG_PACKET_THRESHOLD, REG_PACKET_TIMEOUT,
		REG_RSSI_PWM_TIME, REG_PARITY_SELECT, REG_FLOW_THRESHOLD, REG_SERIAL_HIGH,
		REG_SERIAL_LOW, REG_NETWORK_TAG, REG_OUT3_FUNCTION, REG_PACKET_SIZE,
		REG_SOURCE_ADDRESS, REG_RF_MODE_SELECT, REG_STOP_BITS, REG_TX_POWER_LEVEL
	};

	localparam int          TABLE_DEPTH       = 64;
	localparam logic [7:0]  CODE_STORE        = 8'h08;
	localparam logic [7:0]  LINE2_BINARY      = 8'h01;
	localparam logic [15:0] GUARD_MIN         = 16'h0002;
	localparam logic [15:0] SLEEP_IDLE_MIN    = 16'h0010;
	localparam logic [15:0] RSSI_PWM_MAX      = 16'h007f;
	localparam logic [15:0] NET_TAG_MIN       = 16'h0010;
	localparam logic [15:0] NET_TAG_MAX       = 16'h7fff;
	localparam logic [15:0] FLOW_MARGIN       = 16'h0011;
	localparam logic [15:0] INPUT_BUFFER_SIZE = 16'h0100;
	localparam int          CLK_MHZ           = 100;
	localparam int          ABORT_TIME_MS     = 500;
	localparam int          ABORT_CYCLES      = ABORT_TIME_MS * 1000 * CLK_MHZ;

	typedef enum {ST_IDLE, ST_PARAM_LO, ST_PARAM_HI, ST_EXEC, ST_SEND_LO, ST_SEND_HI, ST_STORE} bcp_state_t;

endpackage

//--- design/bcp_binary_command_port.sv
/*
 * Binary command interpreter on the receive path of the serial port.
 * Assumes a UART receiver delivering one-cycle rx_valid pulses on sys_clk, a transmitter
 * accepting bytes on tx_valid/tx_ready, and an external non-volatile store on nvm_wr_*.
 */
`timescale 1ns/1ps
`default_nettype none

module bcp_binary_command_port #(
	parameter int ABORT_CYCLES = bcp_pkg::ABORT_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	input  wire logic        binary_cmd_select,
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic      [7:0]  payload_data,
	output logic             payload_valid,
	output logic             cts_n,
	input  wire logic        cfg_wr_en,
	input  wire logic [7:0]  cfg_wr_addr,
	input  wire logic [15:0] cfg_wr_data,
	input  wire logic [7:0]  cfg_rd_addr,
	output logic      [15:0] cfg_rd_data,
	output logic             nvm_wr_en,
	output logic      [5:0]  nvm_wr_addr,
	output logic      [15:0] nvm_wr_data,
	input  wire logic [15:0] firmware_version,
	input  wire logic [7:0]  signal_strength,
	input  wire logic [15:0] serial_high,
	input  wire logic [15:0] serial_low
);

	// ------------------------------------------------------------
	// Parameter table lookups
	// ------------------------------------------------------------
	function automatic logic reg_hit(input logic [7:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < bcp_pkg::REG_COUNT; i++)
		begin
			if (bcp_pkg::REG_LIST[i].offset == code)
				hit = 1'b1;
		end
		return hit;
	endfunction

	function automatic bcp_pkg::bcp_reg_t reg_info(input logic [7:0] code);
		bcp_pkg::bcp_reg_t info;
		info = '0;
		for (int i = 0; i < bcp_pkg::REG_COUNT; i++)
		begin
			if (bcp_pkg::REG_LIST[i].offset == code)
				info = bcp_pkg::REG_LIST[i];
		end
		return info;
	endfunction

	// Decides whether a write of val to code may change the table.
	function automatic logic write_ok(input logic [7:0] code, input logic [15:0] val);
		logic ok;
		ok = reg_hit(code) && (reg_info(code).access != bcp_pkg::ACC_RO);
		// Range limits look at the full sixteen-bit value, before any narrowing.
		case (code)
			bcp_pkg::REG_GUARD_AFTER.offset,
			bcp_pkg::REG_COMMAND_IDLE_TIMEOUT.offset:
				ok = ok && (val >= bcp_pkg::GUARD_MIN);
			bcp_pkg::REG_SLEEP_IDLE_DELAY.offset:
				ok = ok && (val >= bcp_pkg::SLEEP_IDLE_MIN);
			bcp_pkg::REG_RSSI_PWM_TIME.offset:
				ok = ok && (val <= bcp_pkg::RSSI_PWM_MAX);
			bcp_pkg::REG_NETWORK_TAG.offset:
				ok = ok && (val >= bcp_pkg::NET_TAG_MIN) && (val <= bcp_pkg::NET_TAG_MAX);
			bcp_pkg::REG_FLOW_THRESHOLD.offset:
				ok = ok && (val <= bcp_pkg::INPUT_BUFFER_SIZE - bcp_pkg::FLOW_MARGIN);
			default:
				ok = ok;
		endcase
		return ok;
	endfunction

	// Narrow parameters keep the low byte only.
	function automatic logic [15:0] fit_width(input logic [7:0] code, input logic [15:0] val);
		return reg_info(code).wide ? val : {8'h00, val[7:0]};
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	bcp_pkg::bcp_state_t state_q;
	logic [15:0]         table_q [bcp_pkg::TABLE_DEPTH];
	logic                sel_meta_q;
	logic                sel_sync_q;
	logic [7:0]          code_q;
	logic [7:0]          param_lo_q;
	logic [15:0]         param_q;
	logic [15:0]         reply_q;
	logic [31:0]         abort_cnt_q;
	logic [5:0]          store_idx_q;
	logic                binary_enabled;
	logic                cmd_byte;
	logic                exec_write;
	logic                abort_due;
	logic [15:0]         reply_value;

	// ------------------------------------------------------------
	// Select pin synchroniser
	// ------------------------------------------------------------
	// Only the second flop is read elsewhere; the first may still be settling.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			sel_meta_q <= 1'b0;
			sel_sync_q <= 1'b0;
		end
		else
		begin
			sel_meta_q <= binary_cmd_select;
			sel_sync_q <= sel_meta_q;
		end
	end

	// ------------------------------------------------------------
	// Byte classification
	// ------------------------------------------------------------
	assign binary_enabled = table_q[bcp_pkg::REG_LINE2_INPUT_FUNCTION.offset[5:0]][7:0]
	                        == bcp_pkg::LINE2_BINARY;
	// The select level is looked at only on the byte's completion pulse.
	assign cmd_byte   = rx_valid && sel_sync_q && binary_enabled;
	assign exec_write = (state_q == bcp_pkg::ST_EXEC) && write_ok(code_q, param_q);
	assign abort_due  = abort_cnt_q >= 32'(ABORT_CYCLES - 1);

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			payload_data  <= 8'h00;
			payload_valid <= 1'b0;
		end
		else
		begin
			payload_valid <= rx_valid && !(sel_sync_q && binary_enabled);
			if (rx_valid)
				payload_data <= rx_data;
		end
	end

	// ------------------------------------------------------------
	// Readback value of a code
	// ------------------------------------------------------------
	function automatic logic [15:0] read_value(input logic [7:0] code);
		logic [15:0] v;
		case (code)
			bcp_pkg::REG_FIRMWARE_VERSION.offset:
				v = firmware_version;
			bcp_pkg::REG_SIGNAL_STRENGTH.offset:
				v = {8'h00, signal_strength};
			bcp_pkg::REG_SERIAL_HIGH.offset:
				v = serial_high;
			bcp_pkg::REG_SERIAL_LOW.offset:
				v = serial_low;
			default:
				v = reg_hit(code) ? table_q[code[5:0]] : 16'h0000;
		endcase
		return v;
	endfunction

	// A process rather than a continuous assignment, so that the value follows the table
	// and the read-only sources as well as the received byte.
	always_comb
	begin
		reply_value = read_value({1'b0, rx_data[6:0]});
	end

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			state_q     <= bcp_pkg::ST_IDLE;
			code_q      <= 8'h00;
			param_lo_q  <= 8'h00;
			param_q     <= 16'h0000;
			reply_q     <= 16'h0000;
			store_idx_q <= 6'h00;
		end
		else
		begin
			case (state_q)
				bcp_pkg::ST_IDLE:
				begin
					if (cmd_byte)
					begin
						code_q <= rx_data;
						if (rx_data[7])
						begin
							// Query form: no parameter bytes follow.
							reply_q <= reply_value;
							if (reg_hit({1'b0, rx_data[6:0]}))
								state_q <= bcp_pkg::ST_SEND_LO;
						end
						else if (rx_data == bcp_pkg::CODE_STORE)
						begin
							store_idx_q <= 6'h00;
							state_q     <= bcp_pkg::ST_STORE;
						end
						else
						begin
							// Module reset has no code of its own; every other code collects two bytes.
							state_q <= bcp_pkg::ST_PARAM_LO;
						end
					end
				end
				bcp_pkg::ST_PARAM_LO:
				begin
					if (abort_due)
						state_q <= bcp_pkg::ST_IDLE;
					else if (cmd_byte)
					begin
						param_lo_q <= rx_data;
						state_q    <= bcp_pkg::ST_PARAM_HI;
					end
				end
				bcp_pkg::ST_PARAM_HI:
				begin
					if (abort_due)
						state_q <= bcp_pkg::ST_IDLE;
					else if (cmd_byte)
					begin
						param_q <= {rx_data, param_lo_q};
						state_q <= bcp_pkg::ST_EXEC;
					end
				end
				bcp_pkg::ST_EXEC:
					state_q <= bcp_pkg::ST_IDLE;
				bcp_pkg::ST_SEND_LO:
				begin
					if (tx_ready)
						state_q <= reg_info({1'b0, code_q[6:0]}).wide ? bcp_pkg::ST_SEND_HI
						                                              : bcp_pkg::ST_IDLE;
				end
				bcp_pkg::ST_SEND_HI:
				begin
					if (tx_ready)
						state_q <= bcp_pkg::ST_IDLE;
				end
				bcp_pkg::ST_STORE:
				begin
					store_idx_q <= store_idx_q + 6'h01;
					if (store_idx_q == 6'(bcp_pkg::TABLE_DEPTH - 1))
						state_q <= bcp_pkg::ST_IDLE;
				end
				default:
					state_q <= bcp_pkg::ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Half-second parameter timer
	// ------------------------------------------------------------
	// Counts from the code byte, so slowly paced parameter bytes do not stretch the limit.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			abort_cnt_q <= 32'h0000_0000;
		else if (state_q == bcp_pkg::ST_PARAM_LO || state_q == bcp_pkg::ST_PARAM_HI)
			abort_cnt_q <= abort_cnt_q + 32'h0000_0001;
		else
			abort_cnt_q <= 32'h0000_0000;
	end

	// ------------------------------------------------------------
	// Parameter table
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < bcp_pkg::TABLE_DEPTH; i++)
				table_q[i] <= reg_info(8'(i)).reset_value;
		end
		else if (exec_write)
			table_q[code_q[5:0]] <= fit_width(code_q, param_q);
		// A text-port write in the same cycle as a binary write is lost; the binary one wins.
		else if (cfg_wr_en && write_ok(cfg_wr_addr, cfg_wr_data))
			table_q[cfg_wr_addr[5:0]] <= fit_width(cfg_wr_addr, cfg_wr_data);
	end

	// The read port answers one cycle after the address.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			cfg_rd_data <= 16'h0000;
		else
			cfg_rd_data <= read_value(cfg_rd_addr);
	end

	// ------------------------------------------------------------
	// Non-volatile store stream
	// ------------------------------------------------------------
	// The stream copies the table as it stands each cycle; a write during a store lands only in part.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			nvm_wr_en   <= 1'b0;
			nvm_wr_addr <= 6'h00;
			nvm_wr_data <= 16'h0000;
		end
		else
		begin
			nvm_wr_en   <= state_q == bcp_pkg::ST_STORE;
			nvm_wr_addr <= store_idx_q;
			nvm_wr_data <= table_q[store_idx_q];
		end
	end

	// ------------------------------------------------------------
	// Reply bytes and flow control
	// ------------------------------------------------------------
	// The low reply byte is loaded while idle, so it stands on the first cycle of tx_valid.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			tx_data <= 8'h00;
		else if (state_q == bcp_pkg::ST_SEND_LO && tx_ready)
			tx_data <= reply_q[15:8];
		else if (state_q == bcp_pkg::ST_IDLE)
			tx_data <= reply_value[7:0];
	end

	assign tx_valid = state_q == bcp_pkg::ST_SEND_LO || state_q == bcp_pkg::ST_SEND_HI;
	// Command bytes that arrive during a reply, a store or the execute cycle are dropped; the host must pace itself.
	assign cts_n    = state_q != bcp_pkg::ST_IDLE;

endmodule

`default_nettype wire

//--- test/bcp_props.sv
/*
 * Assertion checker for the binary command port, bound to its top module.
 * Assumes the select pin is synchronised by two flops and binary mode is enabled through the cfg port.
 */
`timescale 1ns/1ps
`default_nettype none

module bcp_props #(
	parameter int ABORT_CYCLES = 200
) (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic [7:0]  rx_data,
	input wire logic        rx_valid,
	input wire logic        binary_cmd_select,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	input wire logic [7:0]  payload_data,
	input wire logic        payload_valid,
	input wire logic        cts_n,
	input wire logic        cfg_wr_en,
	input wire logic [7:0]  cfg_wr_addr,
	input wire logic [15:0] cfg_wr_data,
	input wire logic        nvm_wr_en,
	input wire logic [5:0]  nvm_wr_addr
);
	logic sel1_q;
	logic sel2_q;
	logic en_q;
	int   wait_q;

	always_ff @(posedge sys_clk)
	begin
		sel1_q <= binary_cmd_select;
		sel2_q <= sel1_q;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			en_q <= 1'b0;
		else if (cfg_wr_en && cfg_wr_addr == 8'h16)
			en_q <= (cfg_wr_data[7:0] == 8'h01);
	end

	// Counts quiet cycles spent inside a command, used to bound the abandon time.
	always_ff @(posedge sys_clk)
	begin
		if (reset || !cts_n || rx_valid || tx_valid || nvm_wr_en)
			wait_q <= 0;
		else
			wait_q <= wait_q + 1;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_cmd;
		rx_valid && sel2_q && en_q;
	endsequence
	sequence s_pay;
		rx_valid && !(sel2_q && en_q);
	endsequence
	sequence s_start;
		s_cmd ##0 (!cts_n && !rx_data[7]);
	endsequence

	a_payload_copy: assert property (s_pay |=> payload_valid && payload_data == $past(rx_data))
		else $error("payload byte not passed through");
	a_cmd_hidden: assert property (s_cmd |=> !payload_valid)
		else $error("command byte leaked as payload");
	a_cts_rise: assert property (s_start |=> cts_n)
		else $error("cts_n not raised after command byte");
	a_cts_holds: assert property (s_start ##1 (!rx_valid)[*3] |-> cts_n)
		else $error("cts_n dropped while command pending");
	a_reply_cts: assert property (tx_valid |-> cts_n)
		else $error("reply sent without cts_n high");
	a_reply_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply byte changed before accepted");
	a_store_start: assert property ($rose(nvm_wr_en) |-> nvm_wr_addr == 6'h00 && cts_n)
		else $error("store burst not starting at zero");
	a_store_step: assert property (nvm_wr_en && nvm_wr_addr != 6'h3f |=> nvm_wr_en && nvm_wr_addr == $past(nvm_wr_addr) + 6'h01)
		else $error("store burst broken");
	a_abort_bound: assert property (wait_q <= ABORT_CYCLES + 4)
		else $error("incomplete command not abandoned");
endmodule

bind bcp_binary_command_port bcp_props #(.ABORT_CYCLES(ABORT_CYCLES)) u_props (.sys_clk, .reset, .rx_data,
	.rx_valid, .binary_cmd_select, .tx_data, .tx_valid, .tx_ready, .payload_data, .payload_valid, .cts_n,
	.cfg_wr_en, .cfg_wr_addr, .cfg_wr_data, .nvm_wr_en, .nvm_wr_addr);

`default_nettype wire

//--- test/bcp_host_model.sv
/*
 * Host model: sends serial bytes, drives the select pin and takes reply bytes.
 * Assumes the bench calls its tasks and drives everything at the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module bcp_host_model #(
	parameter int HOLD_CYCLES = 10000
) (
	input  wire logic       sys_clk,
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	output logic            binary_cmd_select,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic       slow = 1'b0;
	logic [7:0] reply_q [$];

	initial
	begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		binary_cmd_select = 1'b0;
	end

	always @(negedge sys_clk)
		tx_ready <= slow ? ~tx_ready : 1'b1;

	always @(posedge sys_clk)
		if (tx_valid && tx_ready)
			reply_q.push_back(tx_data);

	// Bytes go out regardless of cts_n, as with flow control off.
	task automatic send(input logic [7:0] b);
		@(negedge sys_clk);
		rx_data = b;
		rx_valid = 1'b1;
		@(negedge sys_clk);
		rx_valid = 1'b0;
		rx_data = ~b;
		@(negedge sys_clk);
	endtask

	task automatic select(input logic v);
		if (!v)
			repeat (HOLD_CYCLES) @(negedge sys_clk);
		binary_cmd_select = v;
		repeat (3) @(negedge sys_clk);
	endtask

	task automatic command(input logic [7:0] code, input logic [15:0] v, input int n);
		send(code);
		if (n > 0)
			send(v[7:0]);
		if (n > 1)
			send(v[15:8]);
	endtask
endmodule

`default_nettype wire

//--- test/bcp_binary_command_port_tb.sv
/*
 * Self-checking bench for the binary command port with a host model on the serial side.
 * Assumes the design parameter table package and a shortened abandon count.
 */
`timescale 1ns/1ps
`default_nettype none

module bcp_binary_command_port_tb;
	localparam int ABORT = 200;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  rx_data, tx_data, payload_data, cfg_wr_addr, cfg_rd_addr, ss, pay_last;
	logic        rx_valid, sel, tx_valid, tx_ready, payload_valid, cts_n, cfg_wr_en, nvm_wr_en;
	logic [15:0] cfg_wr_data, cfg_rd_data, nvm_wr_data, fw, sh, sl, lfsr, v, old;
	logic [5:0]  nvm_wr_addr;
	logic [15:0] nvm_first;
	int          num_errors, compares, pay_count, nvm_count;
	logic [7:0]  codes [13] = '{8'h05, 8'h05, 8'h02, 8'h02, 8'h22, 8'h22, 8'h27, 8'h27, 8'h24, 8'h24, 8'h1c,
		8'h11, 8'h00};
	logic [15:0] vals [13] = '{16'h0001, 16'h0002, 16'h000f, 16'h0010, 16'h0080, 16'h007f, 16'h8000, 16'h0010,
		16'h00f0, 16'h00ef, 16'h0020, 16'h5aa5, 16'hffff};
	logic [7:0]  rnd_codes [5] = '{8'h00, 8'h03, 8'h1a, 8'h21, 8'h06};

	always #5 sys_clk = ~sys_clk;

	bcp_binary_command_port #(.ABORT_CYCLES(ABORT)) dut (.sys_clk(sys_clk), .reset(reset), .rx_data(rx_data),
		.rx_valid(rx_valid), .binary_cmd_select(sel), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.payload_data(payload_data), .payload_valid(payload_valid), .cts_n(cts_n), .cfg_wr_en(cfg_wr_en),
		.cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data),
		.nvm_wr_en(nvm_wr_en), .nvm_wr_addr(nvm_wr_addr), .nvm_wr_data(nvm_wr_data), .firmware_version(fw),
		.signal_strength(ss), .serial_high(sh), .serial_low(sl));

	bcp_host_model host (.sys_clk(sys_clk), .rx_data(rx_data), .rx_valid(rx_valid), .binary_cmd_select(sel),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

	always @(posedge sys_clk)
	begin
		if (payload_valid)
		begin
			pay_count++;
			pay_last = payload_data;
		end
		if (nvm_wr_en)
			nvm_count++;
		if (nvm_wr_en && nvm_wr_addr == 6'h00)
			nvm_first = nvm_wr_data;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [15:0] expect_val(input logic [7:0] c, input logic [15:0] x, input logic [15:0] o);
		case (c)
			8'h05, 8'h06: return (x >= 16'h0002) ? x : o;
			8'h02: return (x >= 16'h0010) ? x : o;
			8'h22: return (x <= 16'h007f) ? x : o;
			8'h27: return (x >= 16'h0010 && x <= 16'h7fff) ? x : o;
			8'h24: return (x <= bcp_pkg::INPUT_BUFFER_SIZE - 16'h0011) ? x : o;
			8'h1c: return o;
			8'h11: return {8'h00, x[7:0]};
			default: return x;
		endcase
	endfunction

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge sys_clk);
		cfg_rd_addr = a;
		@(negedge sys_clk);
		d = cfg_rd_data;
	endtask

	task automatic wr_reg(input logic [7:0] c, input logic [15:0] x);
		rd(c, old);
		host.command(c, x, 2);
		rd(c, v);
		check("register value", expect_val(c, x, old), v);
	endtask

	task automatic summarize;
		$display("Comparisons %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		#500_000;
		num_errors++;
		summarize();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		lfsr = 16'd57879;
		{cfg_wr_en, cfg_wr_addr, cfg_wr_data, cfg_rd_addr} = '0;
		{fw, sh, sl} = {lfsr, next(lfsr), ~lfsr};
		ss = 8'h06 + lfsr[4:0];
		repeat (2) @(negedge sys_clk);
		reset = 1'b0;
		for (int i = 0; i < bcp_pkg::REG_COUNT; i++)
			if (bcp_pkg::REG_LIST[i].access == bcp_pkg::ACC_RW)
			begin
				rd(bcp_pkg::REG_LIST[i].offset, v);
				check("reset value", bcp_pkg::REG_LIST[i].reset_value, v);
			end
		host.select(1'b1);
		host.command(8'h00, 16'h1a0d, 2);
		check("payload while disabled", 16'd3, 16'(pay_count));
		rd(8'h00, v);
		check("dest unchanged", 16'h0000, v);
		@(negedge sys_clk);
		cfg_wr_en = 1'b1;
		cfg_wr_addr = 8'h16;
		cfg_wr_data = 16'h0001;
		@(negedge sys_clk);
		cfg_wr_en = 1'b0;
		wr_reg(8'h00, 16'h1a0d);
		check("no payload in command", 16'd3, 16'(pay_count));
		host.slow = 1'b1;
		host.command(8'h80, 16'h0000, 0);
		repeat (20) @(negedge sys_clk);
		check("reply count", 16'd2, 16'(host.reply_q.size()));
		check("reply low", 16'h000d, {8'h00, host.reply_q.pop_front()});
		check("reply high", 16'h001a, {8'h00, host.reply_q.pop_front()});
		host.command(8'h9c, 16'h0000, 0);
		repeat (20) @(negedge sys_clk);
		check("strength reply", {8'h00, ss}, {8'h00, host.reply_q.pop_front()});
		host.command(8'ha5, 16'h0000, 0);
		repeat (20) @(negedge sys_clk);
		check("serial reply", sh, {host.reply_q[1], host.reply_q[0]});
		host.reply_q.delete();
		rd(8'h14, v);
		check("version read", fw, v);
		rd(8'h26, v);
		check("serial low read", sl, v);
		host.slow = 1'b0;
		for (int i = 0; i < 13; i++)
			wr_reg(codes[i], vals[i]);
		host.command(8'h40, 16'h1234, 2);
		rd(8'h00, v);
		check("unknown code", 16'hffff, v);
		repeat (8)
		begin
			lfsr = next(lfsr);
			wr_reg(rnd_codes[lfsr[2:0] % 5], lfsr);
		end
		rd(8'h02, old);
		host.command(8'h02, 16'h0055, 1);
		repeat (ABORT + 20) @(negedge sys_clk);
		check("idle after abandon", 16'h0000, {15'h0000, cts_n});
		rd(8'h02, v);
		check("abandoned value", old, v);
		wr_reg(8'h02, 16'h0040);
		rd(8'h00, old);
		nvm_count = 0;
		host.send(8'h08);
		repeat (80) @(negedge sys_clk);
		check("store count", 16'd64, 16'(nvm_count));
		check("stored dest", old, nvm_first);
		host.select(1'b0);
		nvm_count = pay_count;
		host.send(8'h42);
		check("payload again", 16'(nvm_count + 1), 16'(pay_count));
		check("payload byte", 16'h0042, {8'h00, pay_last});
		summarize();
	end
endmodule

`default_nettype wire
